// ==== verilog/nibble_exec_params.svh ====
`ifndef NIBBLE_EXEC_PARAMS_SVH
`define NIBBLE_EXEC_PARAMS_SVH

// ****************************************
// Reset values.
// ****************************************
`define RST_PC 14'h0000
`define RST_NIB 4'h0
`define RST_IE 10'h000

// ****************************************
// Data memory banks and fixed windows.
// ****************************************
`define BANK_ZERO 4'h0
`define BANK_TOP 4'hF
`define DIRECT_LOW_LIMIT 8'h80
`define FAST_ROW_BITS 2'b11
`define PERIPH_ROW_BITS 2'b11

// ****************************************
// Skip costs in machine cycles.
// ****************************************
`define SKIP_SHORT 2'h1
`define SKIP_LONG 2'h2
`define SKIP_TABLE 2'h1
`define LONG_BYTES 2'h3

// ****************************************
// Short relative branch reach.
// ****************************************
`define REL_BACK_FAR 9'sh00F
`define REL_BACK_NEAR 9'sh001
`define REL_FWD_NEAR 9'sh002
`define REL_FWD_FAR 9'sh010

// ****************************************
// Clocks per machine cycle, as shift counts.
// ****************************************
`define DIV_SHIFT0 3'h0
`define DIV_SHIFT1 3'h1
`define DIV_SHIFT2 3'h2
`define DIV_SHIFT3 3'h4

`endif

// ==== verilog/nibble_exec_pkg.sv ====
`default_nettype none

package nibble_exec_pkg;

   // ****************************************
   // Decoded operations.
   // ****************************************
   typedef enum logic [4:0] {
      OP_NOP, OP_MOV_A_MEM, OP_MOV_MEM_A, OP_XCH_A_MEM, OP_MOV_XA_RP, OP_SUBTRACT_WITH_BORROW_RP,
      OP_ROTATE_RIGHT_THROUGH_CARRY, OP_INCS_REG, OP_SKT_CY, OP_MOV1_CY_BIT, OP_MOV1_BIT_CY, OP_BR_REL,
      OP_BRCB, OP_BR_ABS, OP_BRA_EXT, OP_CALLF, OP_MOVT_BCDE, OP_TABLE_INDIRECT_EXECUTE, OP_IE_SET, OP_IE_CLR
   } op_t;

   // ****************************************
   // Data memory addressing classes.
   // ****************************************
   typedef enum logic [2:0] {
      AM_HL, AM_HLINC, AM_HLDEC, AM_DE, AM_DL, AM_MEM, AM_FMEM, AM_PMEM_L
   } am_t;

   // ****************************************
   // Interrupt enable sources.
   // ****************************************
   typedef enum logic [3:0] {
      SRC_BASIC_TIMER, SRC_TIMER0, SRC_TIMER1, SRC_TIMER2, SRC_EXT0, SRC_EXT1,
      SRC_EXT2, SRC_EXT4, SRC_SERIAL, SRC_WATCH
   } irq_src_t;

   // ****************************************
   // One decoded instruction.
   // ****************************************
   typedef struct packed {
      op_t op;
      am_t mode;
      logic [2:0] pair;
      logic [1:0] bitsel;
      logic [1:0] bytes;
      logic [1:0] cycles;
      logic [7:0] imm8;
      logic [13:0] imm14;
   } instr_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01
   } state_t;

endpackage

`default_nettype wire

// ==== verilog/nibble_exec.sv ====
// Contract
// - Skip costs 0 cycles if none, 1 for short, 2 for long branch/call.
// - Skipping a table-indirect execute always costs exactly one machine cycle.
// - Machine cycle is 1, 2, 4 or 16 CPU clocks, selectable among four periods.
// - Direct address: flag clear maps low half bank 0, high half bank 15.
// - DE and DL pointer accesses always use bank 0.
// - Fast bit operands hit bank 15 at FB0H-FBFH or FF0H-FFFH.
// - Peripheral bit operands hit bank 15 within FC0H-FFFH.
// - L-indexed bit: nibble from operand 5-2 and L 3-2, bit L 1-0.
// - Short relative branch reaches PC-15..PC-1 or PC+2..PC+16 only.
// - In-block branch keeps PC bits 13-12, replaces low twelve bits.
// - Fast call target is an 11-bit immediate within 0000H-07FFH.
// - Only low two bits of B form the table address high part.
// - Extended pair operand selects among eight 8-bit pairs.
// - Extended absolute branch takes effect only in extended compat mode.
// - Interrupt enable operand selects one of ten source enables.
// - HL post-adjust accesses first, then skips on L wrap.
// - Rotate right: bit 0 to carry, carry to bit 3.
// - Subtract with borrow on pair: pair minus XA minus carry.
// - Pointer operands are HL, HL+, HL-, DE and DL.
`timescale 1ns/1ps
`default_nettype none
`include "nibble_exec_params.svh"

module nibble_exec import nibble_exec_pkg::*; (
   // Clock and reset.
   input wire logic CLOCK,
   input wire logic RST,
   // Decoded instruction stream.
   input wire instr_t INSTR,
   input wire logic INSTR_VALID,
   output logic INSTR_READY,
   // Configuration.
   input wire logic MEM_BANK_ENABLE_FLAG,
   input wire logic [3:0] MEM_BANK_SELECT,
   input wire logic [1:0] CPU_CLOCK_CONTROL,
   input wire logic EXTENDED_COMPAT_MODE,
   // Data memory.
   output logic [11:0] DMEM_ADDR,
   output logic DMEM_WE,
   output logic [3:0] DMEM_WDATA,
   input wire logic [3:0] DMEM_RDATA,
   // Program memory.
   output logic [13:0] PMEM_ADDR,
   input wire logic [7:0] PMEM_RDATA,
   // Core state.
   output logic [13:0] PC,
   output logic [7:0] WIDE_ACCUMULATOR_PAIR,
   output logic CARRY_FLAG,
   output logic SKIP_PENDING,
   output logic [9:0] SOURCE_IRQ_ENABLE
);

   // ****************************************
   // Storage and control state.
   // ****************************************
   logic [3:0] rf_q [16];
   logic [3:0] rf_d [16];
   logic cy_q, cy_d, skip_q, skip_d;
   logic [13:0] pc_q, pc_d;
   logic [9:0] ie_q, ie_d;
   state_t state_q, state_d;
   logic [5:0] cnt_q, cnt_d, cnt_init;
   logic ready_q, sup_q, accept, commit;
   instr_t cur_q;
   logic [1:0] bit_q, bit_a, scyc;
   logic [2:0] sh;
   logic [7:0] tb_q;
   logic [11:0] addr_a;
   logic [3:0] bank_a;
   logic [7:0] pv, xa;
   logic [8:0] diff;
   logic signed [8:0] off;
   logic rel_ok;
   logic [3:0] lnew, wnib;
   logic wr_fast, wr_late;

   assign accept = INSTR_VALID && ready_q;
   assign commit = (state_q == ST_EXEC) && (cnt_q == 6'h00);
   assign pv = {rf_q[{cur_q.pair, 1'b1}], rf_q[{cur_q.pair, 1'b0}]};
   assign xa = {rf_q[1], rf_q[0]};
   assign diff = {1'b0, pv} - {1'b0, xa} - {8'h00, cy_q};
   assign off = {cur_q.imm8[7], cur_q.imm8};
   // Targets outside the two reachable windows are not taken.
   assign rel_ok = ((off >= -`REL_BACK_FAR) && (off <= -`REL_BACK_NEAR)) ||
                   ((off >= `REL_FWD_NEAR) && (off <= `REL_FWD_FAR));
   assign lnew = (cur_q.mode == AM_HLINC) ? rf_q[6] + 4'h1 : rf_q[6] - 4'h1;

   // ****************************************
   // Machine cycle length and skip cost.
   // ****************************************
   // Clocks per machine cycle follow the cpu clock control setting.
   always_comb begin
      case (CPU_CLOCK_CONTROL)
         2'h0: sh = `DIV_SHIFT0;
         2'h1: sh = `DIV_SHIFT1;
         2'h2: sh = `DIV_SHIFT2;
         default: sh = `DIV_SHIFT3;
      endcase
      if (INSTR.op == OP_TABLE_INDIRECT_EXECUTE) begin
         scyc = `SKIP_TABLE;
      end else if (INSTR.bytes == `LONG_BYTES) begin
         scyc = `SKIP_LONG;
      end else begin
         scyc = `SKIP_SHORT;
      end
      cnt_init = 6'(6'(skip_d ? scyc : INSTR.cycles) << sh) - 6'h01;
   end

   // ****************************************
   // Sequencing.
   // ****************************************
   // Next state and remaining clocks of the running instruction.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (state_q == ST_EXEC && cnt_q != 6'h00) begin
         cnt_d = cnt_q - 6'h01;
      end
      if (commit) begin
         state_d = ST_IDLE;
      end
      if (accept) begin
         state_d = ST_EXEC;
         cnt_d = cnt_init;
      end
   end

   // Control registers of the sequencer.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_q <= ST_IDLE;
         cnt_q <= 6'h00;
         ready_q <= 1'b1;
         sup_q <= 1'b0;
         bit_q <= 2'h0;
         cur_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ready_q <= (state_d == ST_IDLE) || (cnt_d == 6'h00);
         if (accept) begin
            cur_q <= INSTR;
            sup_q <= skip_d;
            bit_q <= bit_a;
         end
      end
   end

   // ****************************************
   // Data memory address at acceptance.
   // ****************************************
   // Pointers use the register values as they stand after any same-edge commit.
   always_comb begin
      bank_a = MEM_BANK_ENABLE_FLAG ? MEM_BANK_SELECT : `BANK_ZERO;
      bit_a = INSTR.bitsel;
      case (INSTR.mode)
         AM_HL, AM_HLINC, AM_HLDEC: addr_a = {bank_a, rf_d[7], rf_d[6]};
         AM_DE: addr_a = {`BANK_ZERO, rf_d[5], rf_d[4]};
         AM_DL: addr_a = {`BANK_ZERO, rf_d[5], rf_d[6]};
         AM_MEM: begin
            if (MEM_BANK_ENABLE_FLAG) begin
               addr_a = {MEM_BANK_SELECT, INSTR.imm8};
            end else if (INSTR.imm8 < `DIRECT_LOW_LIMIT) begin
               addr_a = {`BANK_ZERO, INSTR.imm8};
            end else begin
               addr_a = {`BANK_TOP, INSTR.imm8};
            end
         end
         AM_FMEM: addr_a = {`BANK_TOP, 1'b1, INSTR.imm8[6], `FAST_ROW_BITS, INSTR.imm8[3:0]};
         AM_PMEM_L: begin
            addr_a = {`BANK_TOP, `PERIPH_ROW_BITS, INSTR.imm8[5:2], rf_d[6][3:2]};
            bit_a = rf_d[6][1:0];
         end
         default: addr_a = {bank_a, INSTR.imm8};
      endcase
   end

   // ****************************************
   // Data memory strobes.
   // ****************************************
   // Writes land at the edge that ends the instruction, and only when not skipped.
   always_comb begin
      wr_fast = accept && (cnt_init == 6'h00) && !skip_d &&
                (INSTR.op == OP_MOV_MEM_A || INSTR.op == OP_XCH_A_MEM);
      wr_late = (state_q == ST_EXEC) && (cnt_q == 6'h01) && !sup_q &&
                (cur_q.op == OP_MOV_MEM_A || cur_q.op == OP_XCH_A_MEM || cur_q.op == OP_MOV1_BIT_CY);
      wnib = DMEM_RDATA;
      wnib[bit_q] = cy_q;
   end

   // Address, write enable and write data toward data memory.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         DMEM_ADDR <= 12'h000;
         DMEM_WE <= 1'b0;
         DMEM_WDATA <= 4'h0;
      end else begin
         DMEM_WE <= wr_fast || wr_late;
         if (accept) begin
            DMEM_ADDR <= addr_a;
         end
         if (wr_fast) begin
            DMEM_WDATA <= rf_d[0];
         end else if (wr_late) begin
            DMEM_WDATA <= (cur_q.op == OP_MOV1_BIT_CY) ? wnib : rf_q[0];
         end
      end
   end

   // ****************************************
   // Program memory reads.
   // ****************************************
   // Table reads take B bits 1-0 only; table execute fetches two bytes.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         PMEM_ADDR <= 14'h0000;
         tb_q <= 8'h00;
      end else if (accept) begin
         PMEM_ADDR <= (INSTR.op == OP_MOVT_BCDE) ? {rf_d[3][1:0], rf_d[2], rf_d[5], rf_d[4]}
                                                 : {6'h00, INSTR.imm8};
      end else if (state_q == ST_EXEC && cnt_q == 6'h01 && cur_q.op == OP_TABLE_INDIRECT_EXECUTE) begin
         tb_q <= PMEM_RDATA;
         PMEM_ADDR <= PMEM_ADDR + 14'h0001;
      end
   end

   // ****************************************
   // Architectural effects at commit.
   // ****************************************
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         rf_d[i] = rf_q[i];
      end
      cy_d = cy_q;
      pc_d = pc_q;
      ie_d = ie_q;
      skip_d = skip_q;
      if (commit) begin
         skip_d = 1'b0;
         pc_d = pc_q + {12'h000, cur_q.bytes};
         if (!sup_q) begin
            case (cur_q.op)
               OP_MOV_A_MEM, OP_XCH_A_MEM: begin
                  rf_d[0] = DMEM_RDATA;
                  if (cur_q.mode == AM_HLINC || cur_q.mode == AM_HLDEC) begin
                     rf_d[6] = lnew;
                     skip_d = (cur_q.mode == AM_HLINC) ? (lnew == 4'h0) : (lnew == 4'hF);
                  end
               end
               OP_MOV_XA_RP: begin
                  rf_d[1] = pv[7:4];
                  rf_d[0] = pv[3:0];
               end
               OP_SUBTRACT_WITH_BORROW_RP: begin
                  rf_d[{cur_q.pair, 1'b1}] = diff[7:4];
                  rf_d[{cur_q.pair, 1'b0}] = diff[3:0];
                  cy_d = diff[8];
               end
               OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                  cy_d = rf_q[0][0];
                  rf_d[0] = {cy_q, rf_q[0][3:1]};
               end
               OP_INCS_REG: begin
                  rf_d[cur_q.imm8[3:0]] = rf_q[cur_q.imm8[3:0]] + 4'h1;
                  skip_d = (rf_q[cur_q.imm8[3:0]] == 4'hF);
               end
               OP_SKT_CY: skip_d = cy_q;
               OP_MOV1_CY_BIT: cy_d = DMEM_RDATA[bit_q];
               OP_BR_REL: begin
                  if (rel_ok) begin
                     pc_d = pc_q + 14'(off);
                  end
               end
               OP_BRCB: pc_d = {pc_q[13:12], cur_q.imm14[11:0]};
               OP_BR_ABS: pc_d = cur_q.imm14;
               OP_BRA_EXT: begin
                  if (EXTENDED_COMPAT_MODE) begin
                     pc_d = cur_q.imm14;
                  end
               end
               OP_CALLF: pc_d = {3'h0, cur_q.imm14[10:0]};
               OP_MOVT_BCDE: begin
                  rf_d[1] = PMEM_RDATA[7:4];
                  rf_d[0] = PMEM_RDATA[3:0];
               end
               OP_TABLE_INDIRECT_EXECUTE: pc_d = {tb_q[5:0], PMEM_RDATA};
               OP_IE_SET, OP_IE_CLR: begin
                  if (cur_q.imm8[3:0] <= SRC_WATCH) begin
                     ie_d[cur_q.imm8[3:0]] = (cur_q.op == OP_IE_SET);
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Register file, carry, skip flag, enables and program counter.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         for (int i = 0; i < 16; i++) begin
            rf_q[i] <= `RST_NIB;
         end
         cy_q <= 1'b0;
         skip_q <= 1'b0;
         pc_q <= `RST_PC;
         ie_q <= `RST_IE;
      end else begin
         rf_q <= rf_d;
         cy_q <= cy_d;
         skip_q <= skip_d;
         pc_q <= pc_d;
         ie_q <= ie_d;
      end
   end

   assign INSTR_READY = ready_q;
   assign PC = pc_q;
   assign WIDE_ACCUMULATOR_PAIR = xa;
   assign CARRY_FLAG = cy_q;
   assign SKIP_PENDING = skip_q;
   assign SOURCE_IRQ_ENABLE = ie_q;

   // ****************************************
   // Checks.
   // ****************************************
   property p_skip_long;
      @(posedge CLOCK) disable iff (RST)
      accept && skip_d && INSTR.op != OP_TABLE_INDIRECT_EXECUTE && INSTR.bytes == `LONG_BYTES && CPU_CLOCK_CONTROL == 2'h0
      |=> !ready_q ##1 ready_q;
   endproperty
   a_skip_long: assert property (p_skip_long) else $error("long skip not two cycles");

   property p_skip_table_indirect_execute;
      @(posedge CLOCK) disable iff (RST)
      accept && skip_d && INSTR.op == OP_TABLE_INDIRECT_EXECUTE && CPU_CLOCK_CONTROL == 2'h0 |=> ready_q && commit;
   endproperty
   a_skip_table_indirect_execute: assert property (p_skip_table_indirect_execute) else $error("table skip not one cycle");

   property p_div_two;
      @(posedge CLOCK) disable iff (RST)
      accept && !skip_d && INSTR.cycles == 2'h2 && CPU_CLOCK_CONTROL == 2'h1 |=> !ready_q [*3] ##1 ready_q;
   endproperty
   a_div_two: assert property (p_div_two) else $error("machine cycle length wrong");

   property p_bank_low;
      @(posedge CLOCK) disable iff (RST)
      accept && INSTR.mode == AM_MEM && !MEM_BANK_ENABLE_FLAG && INSTR.imm8[7] == 1'b0
      |=> DMEM_ADDR[11:8] == `BANK_ZERO;
   endproperty
   a_bank_low: assert property (p_bank_low) else $error("direct bank wrong");

   property p_ptr_bank;
      @(posedge CLOCK) disable iff (RST)
      accept && (INSTR.mode == AM_DE || INSTR.mode == AM_DL) |=> DMEM_ADDR[11:8] == `BANK_ZERO;
   endproperty
   a_ptr_bank: assert property (p_ptr_bank) else $error("pointer bank not zero");

   property p_fast_win;
      @(posedge CLOCK) disable iff (RST)
      accept && INSTR.mode == AM_FMEM |=> DMEM_ADDR[11:8] == `BANK_TOP && DMEM_ADDR[7] && DMEM_ADDR[5:4] == 2'h3;
   endproperty
   a_fast_win: assert property (p_fast_win) else $error("fast bit outside window");

   property p_periph_win;
      @(posedge CLOCK) disable iff (RST)
      accept && INSTR.mode == AM_PMEM_L |=> DMEM_ADDR[11:6] == 6'h3F && DMEM_ADDR[1:0] == $past(rf_d[6][3:2]);
   endproperty
   a_periph_win: assert property (p_periph_win) else $error("peripheral bit address wrong");

   property p_block_br;
      @(posedge CLOCK) disable iff (RST)
      commit && !sup_q && cur_q.op == OP_BRCB |=> PC == {$past(pc_q[13:12]), $past(cur_q.imm14[11:0])};
   endproperty
   a_block_br: assert property (p_block_br) else $error("in-block branch target wrong");

   property p_wrap_skip;
      @(posedge CLOCK) disable iff (RST)
      commit && !sup_q && cur_q.op == OP_MOV_A_MEM && cur_q.mode == AM_HLINC && rf_q[6] == 4'hF
      |=> SKIP_PENDING && rf_q[6] == 4'h0;
   endproperty
   a_wrap_skip: assert property (p_wrap_skip) else $error("L wrap did not skip");

   property p_suppress;
      @(posedge CLOCK) disable iff (RST)
      commit && sup_q |=> $stable(CARRY_FLAG) && $stable(WIDE_ACCUMULATOR_PAIR) && !SKIP_PENDING;
   endproperty
   a_suppress: assert property (p_suppress) else $error("skipped instruction had effect");

endmodule // nibble_exec

`default_nettype wire

// ==== verification/nibble_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Program and data memory arrays.
// ****************************************
module nibble_mem_model (
   // Clock.
   input wire logic clk,
   // Data memory.
   input wire logic [11:0] dmem_addr,
   input wire logic dmem_we,
   input wire logic [3:0] dmem_wdata,
   output logic [3:0] dmem_rdata,
   // Program memory.
   input wire logic [13:0] pmem_addr,
   output logic [7:0] pmem_rdata
);
   logic [3:0] dmem [0:4095];
   logic [7:0] pmem [0:16383];

   // Both arrays answer in the same cycle as the address, as the core expects.
   assign dmem_rdata = dmem[dmem_addr];
   assign pmem_rdata = pmem[pmem_addr];

   // A data write lands on the rising edge that closes the strobe cycle.
   always @(posedge clk) begin
      if (dmem_we) begin
         dmem[dmem_addr] <= dmem_wdata;
      end
   end
endmodule // nibble_mem_model

`default_nettype wire

// ==== verification/nibble_cpu_instruction_execute_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module nibble_cpu_instruction_execute_test import nibble_exec_pkg::*;;
   // ****************************************
   // Signals.
   // ****************************************
   logic clk, rst, valid, ready, mem_bank_enable_flag, compat, we, cy, skip, exp_cy, c;
   logic [1:0] ccc, bs;
   logic [2:0] pr;
   logic [3:0] mem_bank_select, wd, rd, x, nb;
   logic [7:0] prd, xa, v8, bc;
   logic [8:0] diff;
   logic [9:0] ie, exp_ie;
   logic [11:0] da;
   logic [13:0] pa, pc, exp_pc, t;
   instr_t instr;
   int fail_count, num_checks, seed, n, off;
   int corner [8] = '{-16, -15, -1, 0, 1, 2, 16, 17};

   nibble_exec dut_u (.CLOCK(clk), .RST(rst), .INSTR(instr), .INSTR_VALID(valid), .INSTR_READY(ready),
      .MEM_BANK_ENABLE_FLAG(mem_bank_enable_flag), .MEM_BANK_SELECT(mem_bank_select), .CPU_CLOCK_CONTROL(ccc),
      .EXTENDED_COMPAT_MODE(compat), .DMEM_ADDR(da), .DMEM_WE(we), .DMEM_WDATA(wd), .DMEM_RDATA(rd),
      .PMEM_ADDR(pa), .PMEM_RDATA(prd), .PC(pc), .WIDE_ACCUMULATOR_PAIR(xa), .CARRY_FLAG(cy),
      .SKIP_PENDING(skip), .SOURCE_IRQ_ENABLE(ie));
   nibble_mem_model mem_u (.clk(clk), .dmem_addr(da), .dmem_we(we), .dmem_wdata(wd), .dmem_rdata(rd),
      .pmem_addr(pa), .pmem_rdata(prd));

   // ****************************************
   // Helpers.
   // ****************************************
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // Issues one instruction at a falling edge, counts its clocks into n and returns after commit.
   task automatic exec(input op_t op, input am_t md, input logic [3:0] byc, input logic [7:0] i8,
                       input logic [13:0] i14);
      instr = '{op, md, pr, bs, byc[3:2], byc[1:0], i8, i14};
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      n = 1;
      while (ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (ready !== 1'b1) begin
         fail_count++;
      end
      @(negedge clk);
      exp_pc = exp_pc + 14'(byc[3:2]);
   endtask

   // Moves to a known program address.
   task automatic jump(input logic [13:0] a);
      exec(OP_BR_ABS, AM_HL, 4'hF, 8'h00, a);
      exp_pc = a;
      check(16'(pc), 16'(exp_pc));
   endtask

   // Loads A from an even direct address in bank zero, then rotates it through the carry.
   task automatic rotate_right_through_carry(input logic [3:0] v);
      mem_u.dmem[12'h010] = v;
      exec(OP_MOV_A_MEM, AM_MEM, 4'hA, 8'h10, 14'h0);
      exec(OP_ROTATE_RIGHT_THROUGH_CARRY, AM_HL, 4'h5, 8'h00, 14'h0);
      check(16'(xa[3:0]), 16'({exp_cy, v[3:1]}));
      exp_cy = v[0];
      check(16'(cy), 16'(exp_cy));
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short well after the expected run length.
   initial begin
      #400000;
      fail_count++;
      summarize();
   end

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      valid = 1'b0;
      instr = '0;
      {mem_bank_enable_flag, compat, ccc, mem_bank_select, pr, bs} = '0;
      {exp_pc, exp_cy, exp_ie, x, bc} = '0;
      seed = 78;
      fail_count = 0;
      num_checks = 0;
      for (int i = 0; i < 16384; i++) begin
         mem_u.pmem[i] = 8'($random(seed));
      end
      for (int i = 0; i < 4096; i++) begin
         mem_u.dmem[i] = 4'($random(seed));
      end
      repeat (2) @(negedge clk);
      rst = 1'b0;
      check(16'({ready, skip, cy, ie}), 16'h1000);
      check(16'(pc), 16'h0000);
      repeat (6) rotate_right_through_carry(4'($random(seed)));
      // Machine cycles stretch with the selected clock ratio.
      for (int i = 0; i < 4; i++) begin
         ccc = 2'(i);
         exec(OP_NOP, AM_HL, 4'h6, 8'h00, 14'h0);
         check(16'(n), 16'((i == 3) ? 32 : (2 << i)));
      end
      ccc = 2'h0;
      // Direct operands follow the bank flag, select and address half.
      for (int i = 0; i < 16; i++) begin
         v8 = 8'($random(seed)) & 8'hFE;
         mem_bank_enable_flag = v8[3];
         mem_bank_select = (v8[2:1] == 2'h3) ? 4'hF : {2'h0, v8[2:1]};
         exec(OP_MOV_A_MEM, AM_MEM, 4'hA, v8, 14'h0);
         t = {2'h0, mem_bank_enable_flag ? mem_bank_select : {4{v8[7]}}, v8};
         check(16'(da), 16'(t));
         check(16'(xa[3:0]), 16'(mem_u.dmem[t[11:0]]));
      end
      mem_bank_enable_flag = 1'b0;
      // Skipped instructions leave no trace but still spend their skip cycles.
      jump(14'h0100);
      for (int i = 0; i < 4; i++) begin
         rotate_right_through_carry(4'h1);
         exec(OP_SKT_CY, AM_HL, 4'h5, 8'h00, 14'h0);
         check(16'(skip), 16'h0001);
         ccc = 2'(i == 1);
         case (i)
            0: exec(OP_ROTATE_RIGHT_THROUGH_CARRY, AM_HL, 4'h5, 8'h00, 14'h0);
            1: exec(OP_IE_SET, AM_HL, 4'hA, 8'h03, 14'h0);
            2: exec(OP_BR_ABS, AM_HL, 4'hF, 8'h00, 14'h2000);
            default: exec(OP_TABLE_INDIRECT_EXECUTE, AM_HL, 4'h7, 8'h20, 14'h0);
         endcase
         check(16'(n), 16'(((i == 2) ? 2 : 1) << ccc));
         check(16'({skip, cy, pc}), 16'({2'b01, exp_pc}));
         check(16'(ie), 16'(exp_ie));
         ccc = 2'h0;
      end
      // Short relative branches, corner offsets first.
      for (int i = 0; i < 16; i++) begin
         off = (i < 8) ? corner[i] : ($random(seed) % 21);
         jump(14'h0800 + 14'(i * 64));
         t = exp_pc;
         exec(OP_BR_REL, AM_HL, 4'h6, 8'(off), 14'h0);
         if ((off >= -15 && off <= -1) || (off >= 2 && off <= 16)) begin
            exp_pc = t + 14'(off);
         end
         check(16'(pc), 16'(exp_pc));
      end
      // In-block branch, fast call and extended branch with and without the mode.
      for (int i = 0; i < 6; i++) begin
         compat = i[0];
         t = 14'($random(seed));
         jump({2'($random(seed)), 12'h100});
         exec(OP_BRCB, AM_HL, 4'hA, 8'h00, t);
         exp_pc = {exp_pc[13:12], t[11:0]};
         check(16'(pc), 16'(exp_pc));
         exec(OP_CALLF, AM_HL, 4'hA, 8'h00, t);
         exp_pc = {3'h0, t[10:0]};
         check(16'(pc), 16'(exp_pc));
         exec(OP_BRA_EXT, AM_HL, 4'hF, 8'h00, ~t);
         exp_pc = compat ? ~t : exp_pc;
         check(16'(pc), 16'(exp_pc));
      end
      // Table-indirect execute through even table entries.
      for (int i = 0; i < 4; i++) begin
         v8 = 8'h20 + 8'(2 * ({$random(seed)} % 48));
         exec(OP_TABLE_INDIRECT_EXECUTE, AM_HL, 4'h7, v8, 14'h0);
         exp_pc = {mem_u.pmem[v8][5:0], mem_u.pmem[v8 + 8'h01]};
         check(16'(pc), 16'(exp_pc));
      end
      // Each enable index sets then clears its own source; indices past nine do nothing.
      for (int i = 0; i < 24; i++) begin
         exec((i < 12) ? OP_IE_SET : OP_IE_CLR, AM_HL, 4'hA, 8'(i % 12), 14'h0);
         if (i % 12 < 10) begin
            exp_ie[i % 12] = (i < 12);
         end
         check(16'(ie), 16'(exp_ie));
      end
      // Pair subtract with borrow, pair read back, then a table read through B and C.
      for (int i = 0; i < 6; i++) begin
         c = 1'($random(seed));
         rotate_right_through_carry({3'h0, c});
         v8 = 8'($random(seed));
         mem_u.dmem[12'h010] = v8[3:0];
         exec(OP_MOV_A_MEM, AM_MEM, 4'hA, 8'h10, 14'h0);
         pr = 3'h1;
         exec(OP_SUBTRACT_WITH_BORROW_RP, AM_HL, 4'hA, 8'h00, 14'h0);
         diff = {1'b0, bc} - {1'b0, x, v8[3:0]} - 9'(c);
         bc = diff[7:0];
         exp_cy = diff[8];
         exec(OP_MOV_XA_RP, AM_HL, 4'hA, 8'h00, 14'h0);
         check(16'({cy, xa}), 16'({exp_cy, bc}));
         pr = 3'h0;
         exec(OP_MOVT_BCDE, AM_HL, 4'h7, 8'h00, 14'h0);
         v8 = mem_u.pmem[{bc[5:4], bc[3:0], 8'h00}];
         check(16'(xa), 16'(v8));
         x = v8[7:4];
      end
      // L-indexed peripheral bits for L values 1 to 15, with the bank settings off to one side.
      mem_bank_enable_flag = 1'b1;
      mem_bank_select = 4'h2;
      for (int k = 1; k < 16; k++) begin
         exec(OP_INCS_REG, AM_HL, 4'h5, 8'h06, 14'h0);
         v8 = 8'($random(seed));
         exec(OP_MOV1_CY_BIT, AM_PMEM_L, 4'hA, v8, 14'h0);
         t = {2'h0, 4'hF, 2'h3, v8[5:2], 2'(k >> 2)};
         exp_cy = mem_u.dmem[t[11:0]][k % 4];
         check(16'({cy, da}), 16'({exp_cy, t[11:0]}));
      end
      // Post-adjusted pointer reads wrap L, skip the next one and use the selected bank.
      exec(OP_MOV_A_MEM, AM_HLINC, 4'h6, 8'h00, 14'h0);
      check(16'({skip, da}), 16'h120F);
      check(16'(xa[3:0]), 16'(mem_u.dmem[12'h20F]));
      exec(OP_NOP, AM_HL, 4'h5, 8'h00, 14'h0);
      exec(OP_MOV_A_MEM, AM_HLDEC, 4'h6, 8'h00, 14'h0);
      check(16'({skip, da}), 16'h1200);
      exec(OP_NOP, AM_HL, 4'h5, 8'h00, 14'h0);
      // DE and DL pointers stay in bank zero whatever the bank settings.
      for (int m = 0; m < 2; m++) begin
         exec(OP_MOV_A_MEM, (m == 1) ? AM_DL : AM_DE, 4'h5, 8'h00, 14'h0);
         check(16'(da), (m == 1) ? 16'h000F : 16'h0000);
      end
      // An exchange through DE swaps A with bank-zero memory in a single cycle.
      nb = mem_u.dmem[12'h000];
      v8 = xa;
      exec(OP_XCH_A_MEM, AM_DE, 4'h5, 8'h00, 14'h0);
      check(16'({xa[3:0], mem_u.dmem[12'h000]}), 16'({nb, v8[3:0]}));
      // Fast bit reads and writes land in the top bank.
      for (int i = 0; i < 8; i++) begin
         v8 = 8'($random(seed));
         mem_bank_select = v8[7] ? 4'hF : 4'h1;
         bs = v8[1:0];
         exec(OP_MOV1_CY_BIT, AM_FMEM, 4'hA, v8, 14'h0);
         t = {2'h0, 4'hF, 1'b1, v8[6], 2'h3, v8[3:0]};
         exp_cy = mem_u.dmem[t[11:0]][bs];
         check(16'({cy, da}), 16'({exp_cy, t[11:0]}));
         nb = mem_u.dmem[t[11:0]];
         nb[~bs] = exp_cy;
         bs = ~bs;
         exec(OP_MOV1_BIT_CY, AM_FMEM, 4'hA, v8, 14'h0);
         check(16'(mem_u.dmem[t[11:0]]), 16'(nb));
      end
      summarize();
   end
endmodule // nibble_cpu_instruction_execute_test

`default_nettype wire
